// file: sram_host_cfg.svh
// timing constants and the bus widths for the strobed static ram host
// assumes a 100 MHz clock and the slower speed grade of the ram
// How it works
// [RQ1] enable falling edge latches the address
// [RQ2] address may change after the hold interval
// [RQ3] read with enable, selects low, store high
// [RQ4] ram latches output word on enable rise
// [RQ5] any select high floats the ram outputs
// [RQ6] ram selected only with both selects low
// [RQ7] enable high with select high ends the cycle
// [RQ8] write only while all four strobes low
// [RQ9] first rising strobe ends and stores the write
// [RQ10] host holds data across the ending edge
// [RQ11] store strobe low turns ram drivers off
// [RQ12] selects first: wait float delay before driving
// [RQ13] store first: host drives data at once
// [RQ14] store rising first shows the written word
// [RQ15] back to back writes may keep store low
// [RQ16] several modifications allowed while enable low
// [RQ17] memory is 256 words of 4 bits
// [RQ18] address latch 8 bits, fixed per cycle
// [RQ19] ram never drives while store strobe low
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH
`define CLK_PERIOD_NS       10
`define ADDR_HOLD_NS        50
`define ACCESS_NS           300
`define DATA_SETUP_NS       150
`define DATA_HOLD_NS        0
`define FLOAT_DELAY_NS      30
`define PULSE_HIGH_NS       100
`define WRITE_PULSE_NS      180
`define CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC   `CYC(`ADDR_HOLD_NS)
`define ACCESS_CYC `CYC(`ACCESS_NS)
`define SETUP_CYC  `CYC(`DATA_SETUP_NS)
`define FLOAT_CYC  `CYC(`FLOAT_DELAY_NS)
`define HIGH_CYC   `CYC(`PULSE_HIGH_NS)
`define WPULSE_CYC `CYC(`WRITE_PULSE_NS)
`define HOLDD_CYC  1
`define ADDR_W     8
`define DATA_W     4
`define CNT_W      6
`endif

// file: sram_host_pkg.sv
// types for the strobed static ram host
// assumes sram_host_cfg.svh is compiled first
`include "sram_host_cfg.svh"
package sram_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HOLD  = 3'b001,
        ST_WAIT  = 3'b011,
        ST_DRIVE = 3'b010,
        ST_END   = 3'b110,
        ST_HIGH  = 3'b111
    } state_t;
    typedef struct packed {
        state_t                state;
        logic [`CNT_W-1:0]     cnt;
        logic                  wr;
        logic                  en_n;
        logic                  sel_n;
        logic                  st_n;
        logic                  oe;
        logic [`ADDR_W-1:0]    addr;
        logic [`DATA_W-1:0]    dout;
        logic [`DATA_W-1:0]    rdata;
        logic                  done;
        logic                  busy;
    } host_t;
endpackage : sram_host_pkg

// file: pin_sync.sv
// three stage synchroniser for the ram data pins
// assumes pins are asynchronous to CLOCK; a change counts when the second and third stages agree
`include "sram_host_cfg.svh"
module pin_sync (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [`DATA_W-1:0]   pin,
    output logic      [`DATA_W-1:0]   value
);
    logic [`DATA_W-1:0] s1_q;
    logic [`DATA_W-1:0] s2_q;
    logic [`DATA_W-1:0] s3_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 4'h0;
            s2_q  <= 4'h0;
            s3_q  <= 4'h0;
            value <= 4'h0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                value <= s3_q;
            end
        end
    end
endmodule : pin_sync

// file: sram_host.sv
// host controller driving a strobed 256x4 static ram over its pins
// assumes requests from logic on CLOCK; ram pins sampled via pin_sync
`include "sram_host_cfg.svh"
module sram_host (
    input  wire logic                CLOCK,
    input  wire logic                RSTN,
    input  wire logic                REQ,
    input  wire logic                REQ_WRITE,
    input  wire logic [`ADDR_W-1:0]  REQ_ADDR,
    input  wire logic [`DATA_W-1:0]  REQ_WDATA,
    output logic                     BUSY,
    output logic                     DONE,
    output logic      [`DATA_W-1:0]  RDATA,
    output logic                     CHIP_ON_N,
    output logic                     SEL_ONE_N,
    output logic                     SEL_TWO_N,
    output logic                     STORE_STROBE_N,
    output logic      [`ADDR_W-1:0]  LOC_INPUTS,
    input  wire logic [`DATA_W-1:0]  DATA_PINS_IN,
    output logic      [`DATA_W-1:0]  DATA_PINS_OUT,
    output logic                     DATA_PINS_OE
);
    sram_host_pkg::host_t q;
    sram_host_pkg::host_t d;
    logic [`DATA_W-1:0]   pins_sync;

    pin_sync u_sync (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .pin   (DATA_PINS_IN),
        .value (pins_sync)
    );

    function automatic logic [`CNT_W-1:0] cyc(input int n);
        cyc = n[`CNT_W-1:0];
    endfunction : cyc

    always_comb begin
        d      = q;
        d.done = 1'b0;
        case (q.state)
            sram_host_pkg::ST_IDLE: begin
                if (REQ) begin
                    d.addr  = REQ_ADDR;
                    d.dout  = REQ_WDATA;
                    d.wr    = REQ_WRITE;
                    d.en_n  = 1'b0;            // RQ1
                    d.busy  = 1'b1;
                    d.cnt   = cyc(`HOLD_CYC);
                    d.state = sram_host_pkg::ST_HOLD;
                end
            end
            sram_host_pkg::ST_HOLD: begin
                // address stays until hold passes
                if (q.cnt <= 6'h1) begin     // RQ2
                    // write: store strobe falls on the same edge as the selects
                    if (q.wr) begin
                        d.st_n  = 1'b0;      // RQ13
                        d.oe    = 1'b1;      // RQ13
                        d.cnt   = cyc(`WPULSE_CYC);
                    end else begin
                        d.cnt   = cyc(`ACCESS_CYC + 3);
                    end
                    d.sel_n = 1'b0;          // RQ3 RQ8
                    d.state = sram_host_pkg::ST_WAIT;
                end else begin
                    d.cnt = q.cnt - 6'h1;
                end
            end
            sram_host_pkg::ST_WAIT: begin
                if (q.cnt <= 6'h1) begin
                    if (q.wr) begin
                        // selects rise first, so the ram never drives back
                        d.sel_n = 1'b1;      // RQ9 RQ19
                    end else begin
                        d.rdata = pins_sync; // RQ3
                        d.en_n  = 1'b1;      // RQ4
                    end
                    d.cnt   = cyc(`HOLDD_CYC);
                    d.state = sram_host_pkg::ST_END;
                end else begin
                    d.cnt = q.cnt - 6'h1;
                end
            end
            sram_host_pkg::ST_END: begin
                // data held one cycle past the ending edge
                d.oe    = 1'b0;              // RQ10
                d.sel_n = 1'b1;              // RQ7
                d.st_n  = 1'b1;              // RQ11
                d.en_n  = 1'b1;
                d.cnt   = cyc(`HIGH_CYC);
                d.state = sram_host_pkg::ST_HIGH;
            end
            sram_host_pkg::ST_HIGH: begin
                if (q.cnt <= 6'h1) begin
                    d.busy  = 1'b0;
                    d.done  = 1'b1;
                    d.state = sram_host_pkg::ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 6'h1;
                end
            end
            default: begin
                d.state = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            q.state <= sram_host_pkg::ST_IDLE;
            q.cnt   <= 6'h00;
            q.wr    <= 1'b0;
            q.en_n  <= 1'b1;
            q.sel_n <= 1'b1;
            q.st_n  <= 1'b1;
            q.oe    <= 1'b0;
            q.addr  <= 8'h00;
            q.dout  <= 4'h0;
            q.rdata <= 4'h0;
            q.done  <= 1'b0;
            q.busy  <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign BUSY           = q.busy;
    assign DONE           = q.done;
    assign RDATA          = q.rdata;
    assign CHIP_ON_N      = q.en_n;
    assign SEL_ONE_N      = q.sel_n;         // RQ6
    assign SEL_TWO_N      = q.sel_n;
    assign STORE_STROBE_N = q.st_n;
    assign LOC_INPUTS     = q.addr;          // RQ18
    assign DATA_PINS_OUT  = q.dout;
    assign DATA_PINS_OE   = q.oe;

    // bounded helper count of enable-low time
    logic [9:0] low_cnt_q;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            low_cnt_q <= 10'h000;
        end else if (q.en_n) begin
            low_cnt_q <= 10'h000;
        end else begin
            low_cnt_q <= low_cnt_q + 10'h001;
        end
    end

    addr_stable_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ2
        !q.en_n && !$fell(q.en_n) |-> $stable(q.addr))
        else $error("address moved inside a cycle");
    read_store_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ3
        !q.wr && !q.sel_n |-> q.st_n)
        else $error("store strobe low during read");
    no_conflict_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ12
        q.oe |-> !q.st_n || $past(!q.st_n))
        else $error("host drives while ram may drive");
    store_first_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ13
        $fell(q.sel_n) && q.wr |-> !q.st_n)
        else $error("selects fell before store strobe");
    end_order_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ9
        $rose(q.sel_n) && q.wr |-> q.oe && !q.en_n && !q.st_n)
        else $error("write ended without data or strobes");
    pulse_width_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ8
        $rose(q.sel_n) && q.wr |-> $past(!q.st_n && !q.sel_n, 18))
        else $error("write pulse too short");
    access_wait_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ4
        $rose(q.en_n) && !q.wr |-> low_cnt_q >= 10'd35)
        else $error("read ended before access time");
    select_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ7
        $rose(q.sel_n) |=> q.en_n && !q.oe)
        else $error("cycle did not close");
    done_bound_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // RQ1
        REQ && !q.busy |=> ##[1:80] q.done)
        else $error("request never finished");
    read_c: cover property (@(posedge CLOCK) disable iff (!RSTN)
        q.done && !q.wr);
    write_c: cover property (@(posedge CLOCK) disable iff (!RSTN)
        q.done && q.wr);
    back_c: cover property (@(posedge CLOCK) disable iff (!RSTN)
        q.done ##1 q.busy);
endmodule : sram_host

// file: ram_model.sv
// behavioural 256x4 strobed static ram seen from its pins
// assumes the bench resolves the shared data wire from both drivers
`include "sram_host_cfg.svh"
module ram_model (
    input  wire logic               chip_on_n,
    input  wire logic               sel_one_n,
    input  wire logic               sel_two_n,
    input  wire logic               store_strobe_n,
    input  wire logic [`ADDR_W-1:0] loc_inputs,
    input  wire logic [`DATA_W-1:0] data_in,
    output logic      [`DATA_W-1:0] data_out,
    output logic                    drive
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int ACCESS = 300;
    logic [`DATA_W-1:0] mem [0:255];
    logic [`ADDR_W-1:0] addr_q;
    logic [`DATA_W-1:0] held_q, live;
    logic               ready, sel, wr_on;
    assign sel = !sel_one_n && !sel_two_n;
    assign wr_on = !chip_on_n && sel && !store_strobe_n;
    // wrong word until the access time has run
    assign live = ready ? mem[addr_q] : ~mem[addr_q];
    assign drive = sel && store_strobe_n;
    // released pins show a changing pattern, not the last word
    assign data_out = drive ? (chip_on_n ? held_q : live) : ~live;
    always @(negedge chip_on_n) begin
        addr_q = loc_inputs;
        ready = 1'b0;
        ready <= #ACCESS 1'b1;
    end
    always @(posedge chip_on_n) held_q = live;
    always @(negedge wr_on) mem[addr_q] = data_in;
endmodule : ram_model

// file: strobed_static_ram_256x4_test.sv
// self-checking bench: ram host against the ram model
// assumes the design files and ram_model.sv are compiled first
`include "sram_host_cfg.svh"
module strobed_static_ram_256x4_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic               CLOCK, RSTN, REQ, REQ_WRITE, BUSY, DONE;
    logic [`ADDR_W-1:0] REQ_ADDR, LOC_INPUTS;
    logic [`DATA_W-1:0] REQ_WDATA, RDATA, dout, ram_q, bus;
    logic               CHIP_ON_N, SEL_ONE_N, SEL_TWO_N, STORE_STROBE_N;
    logic               oe, ram_drv, st_q;
    int                 n_fail, comparisons;
    assign bus = oe ? dout : ram_q;
    sram_host u_sram_host (
        .CLOCK, .RSTN, .REQ, .REQ_WRITE, .REQ_ADDR, .REQ_WDATA, .BUSY,
        .DONE, .RDATA, .CHIP_ON_N, .SEL_ONE_N, .SEL_TWO_N,
        .STORE_STROBE_N, .LOC_INPUTS, .DATA_PINS_IN(bus),
        .DATA_PINS_OUT(dout), .DATA_PINS_OE(oe)
    );
    ram_model u_ram_model (
        .chip_on_n(CHIP_ON_N), .sel_one_n(SEL_ONE_N),
        .sel_two_n(SEL_TWO_N), .store_strobe_n(STORE_STROBE_N),
        .loc_inputs(LOC_INPUTS), .data_in(bus), .data_out(ram_q),
        .drive(ram_drv)
    );
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    always @(negedge CLOCK) begin
        if (oe === 1'b1 && ram_drv === 1'b1) begin
            n_fail++;
            $display("Error bus owners expected 1 seen 2");
        end
        if (RSTN !== 1'b1) begin
            st_q <= 1'b0;
        end else begin
            if (st_q === 1'b1 && !(CHIP_ON_N === 1'b0 && SEL_ONE_N === 1'b0
                && STORE_STROBE_N === 1'b0) && oe !== 1'b1) begin
                n_fail++;
                $display("Error data hold expected 1 seen %b", oe);
            end
            st_q <= (CHIP_ON_N === 1'b0 && SEL_ONE_N === 1'b0
                     && STORE_STROBE_N === 1'b0);
        end
    end
    task automatic end_sim();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic issue(input logic w, input logic [7:0] a,
                         input logic [3:0] d);
        @(negedge CLOCK);
        REQ = 1'b1;
        REQ_WRITE = w;
        REQ_ADDR = a;
        REQ_WDATA = d;
        @(negedge CLOCK);
        REQ = 1'b0;
    endtask : issue
    task automatic wait_done();
        int i;
        for (i = 0; i < 100 && DONE !== 1'b1; i++) @(negedge CLOCK);
        if (i == 100) begin
            chk("done", 8'h1, {7'h0, DONE});
            end_sim();
        end
    endtask : wait_done
    task automatic op(input logic w, input logic [7:0] a,
                      input logic [3:0] d);
        issue(w, a, d);
        wait_done();
    endtask : op
    task automatic wr_rd();
        logic [7:0] a [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
        logic [3:0] d [4] = '{4'h1, 4'he, 4'h0, 4'hf};
        for (int i = 0; i < 4; i++) begin
            op(1'b1, a[i], d[i]);
            chk("mem", d[i], u_ram_model.mem[a[i]]);
        end
        for (int i = 0; i < 4; i++) begin
            op(1'b0, a[i], 4'h0);
            chk("rdata", d[i], RDATA);
            chk("drive", 8'h0, ram_drv);
        end
    endtask : wr_rd
    task automatic overwrite();
        op(1'b1, 8'h33, 4'h3);
        op(1'b1, 8'h33, 4'hc);
        op(1'b0, 8'h33, 4'h0);
        chk("rdata", 4'hc, RDATA);
        op(1'b1, 8'h34, 4'h9);
        chk("rdata", 4'hc, RDATA);
    endtask : overwrite
    task automatic refused();
        op(1'b1, 8'h77, 4'h1);
        issue(1'b1, 8'h66, 4'h2);
        repeat (3) @(negedge CLOCK);
        chk("busy", 8'h1, BUSY);
        issue(1'b1, 8'h77, 4'h6);
        wait_done();
        chk("mem", 4'h1, u_ram_model.mem[8'h77]);
        chk("mem", 4'h2, u_ram_model.mem[8'h66]);
    endtask : refused
    task automatic mid_reset();
        issue(1'b1, 8'h12, 4'h5);
        repeat (10) @(negedge CLOCK);
        #2;
        RSTN = 1'b0;
        #1;
        chk("pins", {CHIP_ON_N, SEL_ONE_N, STORE_STROBE_N, oe, BUSY},
            8'h1c);
        repeat (2) @(negedge CLOCK);
        RSTN = 1'b1;
        op(1'b1, 8'h12, 4'ha);
        op(1'b0, 8'h12, 4'h0);
        chk("rdata", 4'ha, RDATA);
    endtask : mid_reset
    initial begin
        n_fail = 0;
        comparisons = 0;
        RSTN = 1'b0;
        REQ = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_ADDR = 8'h00;
        REQ_WDATA = 4'h0;
        repeat (16) @(negedge CLOCK);
        RSTN = 1'b1;
        wr_rd();
        overwrite();
        refused();
        mid_reset();
        end_sim();
    end
endmodule : strobed_static_ram_256x4_test
